// ===== verilog/jdp_pkg.sv
// Package of constants and types for the test access and debug event port
// Notes on behaviour
// - Test data in is captured on rising test clock edges in shift states; those edges are found by sampling on the system clock, which times the test logic.
// - Mode select is sampled on each rising test clock edge and steps the controller.
// - Test data out changes only on falling test clock edges.
// - Test data out is driven only in the two shift states, and floats otherwise, including reset; here it stays driven to the falling edge in exit-1.
// - The test reset input puts the controller in its reset state at on_chip_emulation_module after its system clock synchroniser, with no test clock edge.
// - An external debug request makes the core finish its instruction, save its pipeline, enter debug mode and wait.
// - On entry to debug mode, by request or breakpoint, the event pin is pulled low for exactly three clocks.
// - As an output, the event pin only pulls low or lets go; it is never driven high.
// - Apart from the event line, the emulation module is reached only through the test port pins.
`default_nettype none

package jdp_pkg;

  // ==========================================================
  // Timing and reset values
  localparam logic [1:0] JDP_EVENT_CYCLES = 2'h3;
  localparam logic [4:0] JDP_IR_RESET     = 5'h01;

  // ==========================================================
  // Controller states
  typedef enum logic [15:0] {
    JDP_RESET  = 16'h0001, JDP_IDLE   = 16'h0002, JDP_SEL_DR = 16'h0004,
    JDP_CAP_DR = 16'h0008, JDP_SH_DR  = 16'h0010, JDP_EX1_DR = 16'h0020,
    JDP_PA_DR  = 16'h0040, JDP_EX2_DR = 16'h0080, JDP_UP_DR  = 16'h0100,
    JDP_SEL_IR = 16'h0200, JDP_CAP_IR = 16'h0400, JDP_SH_IR  = 16'h0800,
    JDP_EX1_IR = 16'h1000, JDP_PA_IR  = 16'h2000, JDP_EX2_IR = 16'h4000,
    JDP_UP_IR  = 16'h8000
  } jdp_tap_t;

endpackage : jdp_pkg

`default_nettype wire

// ===== verilog/jdp_sync.sv
// Two-flop synchroniser for one level
`default_nettype none

module jdp_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Level
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : jdp_sync

`default_nettype wire

// ===== verilog/jdp_port.sv
// Test access port controller and debug event pin logic
`default_nettype none

module jdp_port
  import jdp_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Test access pins
  input  wire logic       tck,
  input  wire logic       tms,
  input  wire logic       tdi,
  input  wire logic       trst_n,
  output logic            tdo_o,
  output logic            tdo_oe,
  // Debug event pin, open drain
  input  wire logic       debug_event_pin_i,
  output logic            debug_event_pin_o,
  output logic            debug_event_pin_oe,
  // Core side
  input  wire logic       breakpoint_hit,
  input  wire logic       instr_done,
  output logic            debug_req,
  output logic            save_pipeline,
  output logic            debug_mode,
  input  wire logic       debug_exit,
  output logic [4:0]      ir_value,
  output logic            tap_reset
);

  logic       tck_s, tms_s, tdi_s, trst_s, ev_s;
  logic [4:0] pin_raw;
  logic [4:0] pin_s;

  // ==========================================================
  // Pin synchronisers
  // Tck goes in inverted so its flops reset to the idle-low level: no false edge
  assign pin_raw = {debug_event_pin_i, trst_n, tdi, tms, ~tck};

  for (genvar i = 0; i < 5; i++) begin : g_sync
    jdp_sync i_jdp_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .din     (pin_raw[i]),
      .dout    (pin_s[i])
    );
  end

  assign tck_s  = ~pin_s[0];
  assign tms_s  = pin_s[1];
  assign tdi_s  = pin_s[2];
  assign trst_s = pin_s[3];
  assign ev_s   = pin_s[4];

  typedef struct packed {
    logic       tck_prev;
    jdp_tap_t   tap;
    logic [4:0] ir_sh;
    logic [4:0] ir;
    logic       bypass;
    logic       tdo;
    logic       tdo_en;
    logic       ev_prev;
    logic       pending;
    logic       dbg;
    logic       save;
    logic [1:0] ev_cnt;
  } jdp_state_t;

  jdp_state_t s_q, s_d;
  logic rise, fall, shift_ir, shift_dr;

  assign rise     = tck_s & ~s_q.tck_prev;
  assign fall     = ~tck_s & s_q.tck_prev;
  assign shift_ir = (s_q.tap == JDP_SH_IR);
  assign shift_dr = (s_q.tap == JDP_SH_DR);

  // ==========================================================
  // Next state
  always_comb begin
    s_d          = s_q;
    s_d.tck_prev = tck_s;
    s_d.save     = 1'b0;
    s_d.ev_prev  = ev_s;
    if (rise) begin
      case (s_q.tap)
        JDP_RESET:  s_d.tap = tms_s ? JDP_RESET  : JDP_IDLE;
        JDP_IDLE:   s_d.tap = tms_s ? JDP_SEL_DR : JDP_IDLE;
        JDP_SEL_DR: s_d.tap = tms_s ? JDP_SEL_IR : JDP_CAP_DR;
        JDP_CAP_DR: s_d.tap = tms_s ? JDP_EX1_DR : JDP_SH_DR;
        JDP_SH_DR:  s_d.tap = tms_s ? JDP_EX1_DR : JDP_SH_DR;
        JDP_EX1_DR: s_d.tap = tms_s ? JDP_UP_DR  : JDP_PA_DR;
        JDP_PA_DR:  s_d.tap = tms_s ? JDP_EX2_DR : JDP_PA_DR;
        JDP_EX2_DR: s_d.tap = tms_s ? JDP_UP_DR  : JDP_SH_DR;
        JDP_UP_DR:  s_d.tap = tms_s ? JDP_SEL_DR : JDP_IDLE;
        JDP_SEL_IR: s_d.tap = tms_s ? JDP_RESET  : JDP_CAP_IR;
        JDP_CAP_IR: s_d.tap = tms_s ? JDP_EX1_IR : JDP_SH_IR;
        JDP_SH_IR:  s_d.tap = tms_s ? JDP_EX1_IR : JDP_SH_IR;
        JDP_EX1_IR: s_d.tap = tms_s ? JDP_UP_IR  : JDP_PA_IR;
        JDP_PA_IR:  s_d.tap = tms_s ? JDP_EX2_IR : JDP_PA_IR;
        JDP_EX2_IR: s_d.tap = tms_s ? JDP_UP_IR  : JDP_SH_IR;
        JDP_UP_IR:  s_d.tap = tms_s ? JDP_SEL_DR : JDP_IDLE;
        default:    s_d.tap = JDP_RESET;
      endcase
      if (s_q.tap == JDP_CAP_IR) s_d.ir_sh = JDP_IR_RESET;
      if (shift_ir) s_d.ir_sh = {tdi_s, s_q.ir_sh[4:1]};
      if (s_q.tap == JDP_UP_IR) s_d.ir = s_q.ir_sh;
      if (s_q.tap == JDP_CAP_DR) s_d.bypass = 1'b0;
      if (shift_dr) s_d.bypass = tdi_s;
      if (s_q.tap == JDP_RESET) s_d.ir = JDP_IR_RESET;
    end
    // Output moves only on the falling edge, sampled by the far side next rise
    if (fall) begin
      s_d.tdo_en = shift_ir | shift_dr;
      s_d.tdo    = shift_ir ? s_q.ir_sh[0] : s_q.bypass;
    end
    if (rise && !shift_ir && !shift_dr) s_d.tdo_en = 1'b0;
    // Debug request: wait for instruction boundary, then save and enter
    if (!ev_s && s_q.ev_prev && !s_q.dbg) s_d.pending = 1'b1;
    if (s_q.pending && instr_done) begin
      s_d.pending = 1'b0;
      s_d.save    = 1'b1;
      s_d.dbg     = 1'b1;
      s_d.ev_cnt  = JDP_EVENT_CYCLES;
    end else if (breakpoint_hit && !s_q.dbg) begin
      // A waiting request is retired, else it would re-enter and pulse again
      s_d.pending = 1'b0;
      s_d.dbg    = 1'b1;
      s_d.ev_cnt = JDP_EVENT_CYCLES;
    end else if (s_q.ev_cnt != 2'h0) begin
      s_d.ev_cnt = s_q.ev_cnt - 2'h1;
    end
    if (debug_exit && s_q.dbg && s_q.ev_cnt == 2'h0) s_d.dbg = 1'b0;
    // Test reset wins over everything on the test side
    if (!trst_s) begin
      s_d.tap    = JDP_RESET;
      s_d.ir     = JDP_IR_RESET;
      s_d.tdo_en = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q     <= '0;
      s_q.tap <= JDP_RESET;
      s_q.ir  <= JDP_IR_RESET;
      s_q.tck_prev <= 1'b0;
      s_q.ev_prev  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs; trst also gates the driver at on_chip_emulation_module
  assign tdo_o              = s_q.tdo;
  assign tdo_oe             = s_q.tdo_en & trst_s;
  assign debug_event_pin_o  = 1'b0;
  assign debug_event_pin_oe = (s_q.ev_cnt != 2'h0);
  assign debug_req          = s_q.pending;
  assign save_pipeline      = s_q.save;
  assign debug_mode         = s_q.dbg;
  assign ir_value           = s_q.ir;
  assign tap_reset          = (s_q.tap == JDP_RESET);

endmodule : jdp_port

`default_nettype wire

// ===== tb/jdp_port_assertions.sv
// Checker for the test port and debug event pins
`default_nettype none
module jdp_port_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pins and core side
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic debug_event_pin_o,
  input wire logic debug_event_pin_oe,
  input wire logic debug_req,
  input wire logic instr_done,
  input wire logic save_pipeline,
  input wire logic debug_mode,
  input wire logic tap_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Debug entry
  sequence ack3_s;
    debug_event_pin_oe [*3] ##1 !debug_event_pin_oe;
  endsequence
  sequence entry_s;
    $rose(debug_event_pin_oe) && debug_mode;
  endsequence
  od_low_a: assert property (!debug_event_pin_o)
    else $error("event pin high");
  ack_len_a: assert property ($rose(debug_event_pin_oe) |-> ack3_s)
    else $error("ack length");
  ack_entry_a: assert property ($rose(debug_mode) |-> entry_s)
    else $error("entry without ack");
  save_one_a: assert property (save_pipeline |=> !save_pipeline)
    else $error("save too long");
  save_entry_a: assert property (save_pipeline |-> $rose(debug_mode))
    else $error("save outside entry");
  req_enter_a: assert property (debug_req && instr_done && !debug_mode |-> ##[1:2] debug_mode)
    else $error("no entry");
  // Tap reset is seen only after the pin synchroniser
  trst_init_a: assert property ($fell(trst_n) |-> ##[1:4] tap_reset)
    else $error("no tap reset");
  float_a: assert property (tap_reset [*2] |-> !tdo_oe)
    else $error("tdo driven in reset");
  tdo_fall_a: assert property ($changed(tdo_o) |-> !$past(tck, 2))
    else $error("tdo moved on rise");
endmodule : jdp_port_chk
bind jdp_port jdp_port_chk i_jdp_port_chk (
  .sys_clk            (sys_clk),
  .nrst               (nrst),
  .tck                (tck),
  .trst_n             (trst_n),
  .tdo_o              (tdo_o),
  .tdo_oe             (tdo_oe),
  .debug_event_pin_o  (debug_event_pin_o),
  .debug_event_pin_oe (debug_event_pin_oe),
  .debug_req          (debug_req),
  .instr_done         (instr_done),
  .save_pipeline      (save_pipeline),
  .debug_mode         (debug_mode),
  .tap_reset          (tap_reset)
);
`default_nettype wire

// ===== tb/jdp_tester.sv
// External test and debug controller model
`default_nettype none
module jdp_tester (
  // Pacing clock
  input  wire logic sys_clk,
  // Pins toward the device
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  output logic      ev_pull,
  input  wire logic tdo_o,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {tck, tms, tdi, trst_n, ev_pull} = 5'h0e;
  // ==========================================
  // One 80 ns bit; the clock rests low between frames
  task automatic step(input logic m, input logic d, output logic [1:0] q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge sys_clk);
    q = {tdo_oe, tdo_o};
    tck = 1'b1;
    repeat (4) @(negedge sys_clk);
    tck = 1'b0;
  endtask : step
endmodule : jdp_tester
`default_nettype wire

// ===== tb/tb_jtag_debug_event_port.sv
// Bench for the test port and debug event logic
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_jtag_debug_event_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, nrst = 1'b0, breakpoint_hit = 1'b0, instr_done = 1'b1;
  logic debug_exit = 1'b0, tck, tms, tdi, trst_n, ev_pull, tdo_o, tdo_oe;
  logic debug_event_pin_o, debug_event_pin_oe, debug_req, save_pipeline, debug_mode;
  logic tap_reset;
  logic [4:0] ir_value;
  logic [1:0] q;
  int errors = 0, n_compared = 0, k, n;
  // Pull-up on the event wire
  wire logic debug_event_pin_i = ~ev_pull & (debug_event_pin_oe ? debug_event_pin_o : 1'b1);
  jdp_port i_jdp_port (
    .sys_clk            (sys_clk),
    .nrst               (nrst),
    .tck                (tck),
    .tms                (tms),
    .tdi                (tdi),
    .trst_n             (trst_n),
    .tdo_o              (tdo_o),
    .tdo_oe             (tdo_oe),
    .debug_event_pin_i  (debug_event_pin_i),
    .debug_event_pin_o  (debug_event_pin_o),
    .debug_event_pin_oe (debug_event_pin_oe),
    .breakpoint_hit     (breakpoint_hit),
    .instr_done         (instr_done),
    .debug_req          (debug_req),
    .save_pipeline      (save_pipeline),
    .debug_mode         (debug_mode),
    .debug_exit         (debug_exit),
    .ir_value           (ir_value),
    .tap_reset          (tap_reset)
  );
  jdp_tester i_jdp_tester (
    .sys_clk (sys_clk),
    .tck     (tck),
    .tms     (tms),
    .tdi     (tdi),
    .trst_n  (trst_n),
    .ev_pull (ev_pull),
    .tdo_o   (tdo_o),
    .tdo_oe  (tdo_oe)
  );
  always #5 sys_clk = ~sys_clk;
  // ==========================================
  // Scenarios
  task automatic give_verdict();
    $display("compared %0d wrong %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic wait_mode(input logic v);
    for (k = 0; k < 20 && debug_mode !== v; k++) @(negedge sys_clk);
    if (k == 20) begin errors++; give_verdict(); end
  endtask : wait_mode
  task automatic t_reset();
    i_jdp_tester.trst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    `CHK("tap reset", 1'b1, tap_reset)
    `CHK("ir reset", jdp_pkg::JDP_IR_RESET, ir_value)
    `CHK("tdo float", 1'b0, tdo_oe)
    i_jdp_tester.trst_n = 1'b1;
    $display("reset test done");
  endtask : t_reset
  task automatic t_shift();
    logic [21:0] m = 22'b0011000001011000000110;
    logic [21:0] d = 22'b0001101000000101000000;
    for (k = 0; k < 22; k++) begin
      i_jdp_tester.step(m[k], d[k], q);
      if (k == 6) `CHK("tdo drive", 1'b1, q[1])
      if (k >= 5 && k <= 9) `CHK("ir out", jdp_pkg::JDP_IR_RESET[k-5], q[0])
      if (k >= 16 && k <= 18) `CHK("bypass", d[k-1], q[0])
    end
    `CHK("ir load", 5'h0a, ir_value)
    `CHK("tdo idle", 1'b0, q[1])
    $display("shift test done");
  endtask : t_shift
  task automatic t_event();
    for (int s = 0; s < 2; s++) begin
      if (s == 0) begin
        instr_done = 1'b0;
        i_jdp_tester.ev_pull = 1'b1;
        repeat (6) @(negedge sys_clk);
        `CHK("req pending", 1'b1, debug_req)
        `CHK("boundary wait", 1'b0, debug_mode)
        instr_done = 1'b1;
      end else begin
        breakpoint_hit = 1'b1;
      end
      @(negedge sys_clk);
      breakpoint_hit = 1'b0;
      wait_mode(1'b1);
      `CHK("req retired", 1'b0, debug_req)
      for (n = 0; n < 9 && debug_event_pin_oe === 1'b1; n++) @(negedge sys_clk);
      `CHK("ack cycles", 3, n)
      if (s == 1) begin
        repeat (3) @(negedge sys_clk);
        i_jdp_tester.ev_pull = 1'b1;
        repeat (6) @(negedge sys_clk);
        `CHK("req refused", 1'b0, debug_req)
      end
      i_jdp_tester.ev_pull = 1'b0;
      debug_exit = 1'b1;
      @(negedge sys_clk);
      debug_exit = 1'b0;
      wait_mode(1'b0);
    end
    $display("event test done");
  endtask : t_event
  initial begin
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    t_reset();
    t_shift();
    t_event();
    give_verdict();
  end
endmodule : tb_jtag_debug_event_port
`default_nettype wire
